/* File: cadsc_ctrl.sv */
// Alignment, memory map and delayed-branch control for the core
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Sequential program counter updates always clear bit zero.
// - Odd branch targets fetch with bit zero ignored, no misalign exception.
// - Word data accesses clear the two lowest effective address bits.
// - Halfword accesses clear bit zero; byte accesses pass unchanged.
// - Masking applies only to the adder result, never to source registers.
// - Addresses are one flat 32-bit linear space.
// - Direct window reaches 0FF byte, 1FF halfword, 3FF word.
// - Vector table sits at 000FFC00..000FFFFF after reset, movable later.
// - Fetch handles 16-bit base instructions and 32 or 48-bit extensions.
// - Loads and stores support byte, halfword and word widths.
// - The one instruction after a delayed branch runs before the target.
// - A delayed branch costs one apparent cycle.
// - Only the program counter update is reordered; registers stay in order.
// - Delayed indirect jump uses the register value before the slot.
// - Delayed return uses the return pointer held before the slot.
// - Delayed conditional branch decides on flags before the slot.
// - Delayed call writes the return pointer before the slot runs.
// - No step trace trap between a delayed branch and its slot.
// - No interrupt or NMI accepted between a delayed branch and its slot.
// - Undefined opcode in a slot executes as a no-operation.
// - Plain branch costs two cycles taken, one not taken, no slot.
module cadsc_ctrl
	import cadsc_pkg::*;
(
	input  wire logic          clk_in,          // Core clock, 100 MHz
	input  wire logic          rst_n_in,        // Async reset, active low
	input  wire cadsc_retire_t ret_in,          // Retiring instruction
	input  wire cadsc_dreq_t   dreq_in,         // Data access request
	input  wire logic          irq_req_in,      // Maskable interrupt pending
	input  wire logic          nmi_req_in,      // NMI pending
	input  wire logic          trace_en_in,     // Step trace flag set
	input  wire logic          tbp_we_in,       // Table base pointer write
	input  wire logic [31:0]   tbp_wdata_in,    // Table base pointer data
	input  wire logic [31:0]   rp_wdata_in,     // Return pointer write data
	input  wire logic          rp_we_in,        // Return pointer write (in order)
	output logic [31:0]        pc_out,          // Fetch program counter
	output logic [31:0]        daddr_out,       // Aligned data address
	output cadsc_width_t       dwidth_out,      // Data access width
	output logic               dvalid_out,      // Data access issued
	output logic               dir_err_out,     // Direct address outside window
	output logic [31:0]        rp_out,          // Return pointer
	output logic [31:0]        tbp_out,         // Table base pointer
	output logic               in_slot_out,     // Next retire is a delay slot
	output logic               slot_nop_out,    // Slot undefined op squashed
	output logic               irq_ack_out,     // Interrupt accepted
	output logic               nmi_ack_out,     // NMI accepted
	output logic               trace_trap_out,  // Step trace trap raised
	output logic               stall_out        // Fetch bubble for taken plain branch
);

	cadsc_state_t st_q, st_d;
	logic [31:0]  pc_q, pc_d;
	logic [31:0]  tgt_q;              // Target latched at the branch
	logic         tgt_go_q;           // Slot ends in a redirect
	logic [31:0]  rp_q, tbp_q;
	logic [31:0]  daddr_q;
	cadsc_width_t dwidth_q;
	logic         dvalid_q, dir_err_q, slot_nop_q;
	logic         irq_ack_q, nmi_ack_q, trace_q, stall_q;
	logic         in_slot_q;          // Registered copy of the slot state

	// Decode of the retiring instruction
	wire         is_br     = ret_in.valid && (ret_in.br != CADSC_BR_NONE);
	wire         br_taken  = is_br && ((ret_in.br != CADSC_BR_REL) || ret_in.cond_ok);
	wire         dly_br    = is_br && ret_in.delayed && (st_q == CADSC_ST_RUN);
	wire         slot_ret  = ret_in.valid && (st_q == CADSC_ST_SLOT);
	wire [31:0]  ilen_step = (ret_in.ilen == CADSC_ILEN_48) ? PC_STEP48 :
	                         (ret_in.ilen == CADSC_ILEN_32) ? PC_STEP32 :
	                         PC_STEP16;
	wire [31:0]  seq_pc    = (pc_q + ilen_step) & MASK_HALF;
	wire [31:0]  ret_addr  = pc_q + ilen_step + (ret_in.delayed ? PC_STEP16 : 32'h00000000);
	// Target sampled now, before any slot write lands
	wire [31:0]  br_tgt    = (ret_in.br == CADSC_BR_RET) ? rp_q :
	                         (ret_in.br == CADSC_BR_REL) ? ret_in.rel_tgt :
	                         ret_in.reg_val;
	wire [31:0]  tgt_fetch = br_tgt & MASK_HALF;
	wire         is_call   = is_br && (ret_in.br == CADSC_BR_CALL) && (st_q == CADSC_ST_RUN);

	// Effective address: raw operands add, result alone is masked
	wire [31:0]  ea_sum    = dreq_in.base + dreq_in.index;
	wire [31:0]  ea_mask   = (dreq_in.width == CADSC_W_WORD) ? MASK_WORD :
	                         (dreq_in.width == CADSC_W_HALF) ? MASK_HALF :
	                         MASK_NONE;
	wire [31:0]  dir_lim   = (dreq_in.width == CADSC_W_WORD) ? DIR_LIM_WORD :
	                         (dreq_in.width == CADSC_W_HALF) ? DIR_LIM_HALF :
	                         DIR_LIM_BYTE;
	wire         dir_bad   = dreq_in.valid && dreq_in.direct && (ea_sum > dir_lim);

	// Events are held off while the slot is outstanding
	wire         shield    = (st_q == CADSC_ST_SLOT) || dly_br;

	// Next state and program counter
	always_comb begin
		st_d = st_q;
		pc_d = pc_q;
		case (st_q)
			CADSC_ST_RUN: begin
				if (dly_br) begin
					st_d = CADSC_ST_SLOT;
					pc_d = seq_pc;
				end else if (br_taken) begin
					st_d = CADSC_ST_BUB;
					pc_d = tgt_fetch;
				end else if (ret_in.valid) begin
					pc_d = seq_pc;
				end
			end
			CADSC_ST_SLOT: begin
				if (slot_ret) begin
					st_d = CADSC_ST_RUN;
					pc_d = tgt_go_q ? tgt_q : seq_pc;
				end
			end
			CADSC_ST_BUB: begin
				st_d = CADSC_ST_RUN;
			end
			default: begin
				st_d = CADSC_ST_RUN;
			end
		endcase
	end

	// Control state
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q     <= CADSC_ST_RUN;
			pc_q     <= 32'h00000000;
			tgt_q    <= 32'h00000000;
			tgt_go_q <= 1'b0;
			in_slot_q <= 1'b0;
		end else begin
			st_q     <= st_d;
			in_slot_q <= (st_d == CADSC_ST_SLOT);
			pc_q     <= pc_d;
			if (dly_br) begin
				tgt_q    <= tgt_fetch;
				tgt_go_q <= br_taken;
			end
		end
	end

	// Return pointer: call writes at the branch, slot sees the new value
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rp_q <= 32'h00000000;
		end else if (is_call) begin
			rp_q <= ret_addr;
		end else if (rp_we_in) begin
			rp_q <= rp_wdata_in;
		end
	end

	// Table base pointer, starts at the initial vector region
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tbp_q <= VEC_BASE_RST;
		end else if (tbp_we_in) begin
			tbp_q <= tbp_wdata_in;
		end
	end

	// Data access stage
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			daddr_q   <= 32'h00000000;
			dwidth_q  <= CADSC_W_BYTE;
			dvalid_q  <= 1'b0;
			dir_err_q <= 1'b0;
		end else begin
			daddr_q   <= ea_sum & ea_mask;
			dwidth_q  <= dreq_in.width;
			dvalid_q  <= dreq_in.valid && !dir_bad;
			dir_err_q <= dir_bad;
		end
	end

	// Event acceptance and slot squash
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_ack_q  <= 1'b0;
			nmi_ack_q  <= 1'b0;
			trace_q    <= 1'b0;
			slot_nop_q <= 1'b0;
			stall_q    <= 1'b0;
		end else begin
			nmi_ack_q  <= nmi_req_in && !shield;
			irq_ack_q  <= irq_req_in && !nmi_req_in && !shield;
			trace_q    <= trace_en_in && ret_in.valid && !shield;
			slot_nop_q <= slot_ret && ret_in.undef;
			stall_q    <= (st_d == CADSC_ST_BUB);
		end
	end

	assign pc_out         = pc_q;
	assign daddr_out      = daddr_q;
	assign dwidth_out     = dwidth_q;
	assign dvalid_out     = dvalid_q;
	assign dir_err_out    = dir_err_q;
	assign rp_out         = rp_q;
	assign tbp_out        = tbp_q;
	assign in_slot_out    = in_slot_q;
	assign slot_nop_out   = slot_nop_q;
	assign irq_ack_out    = irq_ack_q;
	assign nmi_ack_out    = nmi_ack_q;
	assign trace_trap_out = trace_q;
	assign stall_out      = stall_q;

	// Checks
	sequence s_dly_issue;
		(st_q == CADSC_ST_RUN) && dly_br;
	endsequence

	property p_pc_even;
		@(posedge clk_in) disable iff (!rst_n_in) pc_q[0] == 1'b0;
	endproperty
	a_pc_even: assert property (p_pc_even) else $error("pc odd");

	property p_word_align;
		@(posedge clk_in) disable iff (!rst_n_in)
		dvalid_q && (dwidth_q == CADSC_W_WORD) |-> daddr_q[1:0] == 2'b00;
	endproperty
	a_word_align: assert property (p_word_align) else $error("word misaligned");

	property p_half_align;
		@(posedge clk_in) disable iff (!rst_n_in)
		dreq_in.valid && !dreq_in.direct && (dreq_in.width == CADSC_W_HALF)
		|=> daddr_q == ($past(ea_sum) & MASK_HALF);
	endproperty
	a_half_align: assert property (p_half_align) else $error("half address wrong");

	property p_slot_next;
		@(posedge clk_in) disable iff (!rst_n_in) s_dly_issue |=> in_slot_out;
	endproperty
	a_slot_next: assert property (p_slot_next) else $error("no slot after branch");

	property p_no_irq_slot;
		@(posedge clk_in) disable iff (!rst_n_in) s_dly_issue |=> !irq_ack_q && !nmi_ack_q;
	endproperty
	a_no_irq_slot: assert property (p_no_irq_slot) else $error("event in slot");

	property p_no_trace_slot;
		@(posedge clk_in) disable iff (!rst_n_in) s_dly_issue |=> !trace_q;
	endproperty
	a_no_trace_slot: assert property (p_no_trace_slot) else $error("trace in slot");

	property p_call_rp;
		@(posedge clk_in) disable iff (!rst_n_in) is_call |=> rp_q == $past(ret_addr);
	endproperty
	a_call_rp: assert property (p_call_rp) else $error("rp not updated");

	property p_plain_taken;
		@(posedge clk_in) disable iff (!rst_n_in)
		(st_q == CADSC_ST_RUN) && br_taken && !ret_in.delayed |=> stall_q ##1 !stall_q;
	endproperty
	a_plain_taken: assert property (p_plain_taken) else $error("taken cost wrong");

	property p_ret_target;
		@(posedge clk_in) disable iff (!rst_n_in)
		s_dly_issue and (ret_in.br == CADSC_BR_RET) |=> tgt_q == ($past(rp_q) & MASK_HALF);
	endproperty
	a_ret_target: assert property (p_ret_target) else $error("return target moved");

	property p_tbp_reset;
		@(posedge clk_in) disable iff (!rst_n_in)
		!$past(tbp_we_in) && !$stable(tbp_q) |-> 1'b0;
	endproperty
	a_tbp_reset: assert property (p_tbp_reset) else $error("table base moved");

	// Slot retirement, used by the redirect and squash checks below
	sequence s_slot_done;
		(st_q == CADSC_ST_SLOT) && slot_ret;
	endsequence

	property p_tbp_init;
		@(posedge clk_in) disable iff (!rst_n_in)
		$rose(rst_n_in) |-> tbp_q == VEC_BASE_RST;
	endproperty
	a_tbp_init: assert property (p_tbp_init) else $error("table base not initial");

	// Expected addresses rebuilt from the raw operands, not from the adder wire
	property p_byte_pass;
		@(posedge clk_in) disable iff (!rst_n_in)
		dreq_in.valid && !dreq_in.direct && (dreq_in.width == CADSC_W_BYTE)
		|=> daddr_q == ($past(dreq_in.base) + $past(dreq_in.index));
	endproperty
	a_byte_pass: assert property (p_byte_pass) else $error("byte address altered");

	property p_word_addr;
		@(posedge clk_in) disable iff (!rst_n_in)
		dreq_in.valid && !dreq_in.direct && (dreq_in.width == CADSC_W_WORD)
		|=> daddr_q == (($past(dreq_in.base) + $past(dreq_in.index)) & MASK_WORD);
	endproperty
	a_word_addr: assert property (p_word_addr) else $error("word address wrong");

	// A direct access past its window is dropped, never issued
	property p_dir_block;
		@(posedge clk_in) disable iff (!rst_n_in)
		dreq_in.valid && dreq_in.direct && (ea_sum > dir_lim) |=> dir_err_q && !dvalid_q;
	endproperty
	a_dir_block: assert property (p_dir_block) else $error("direct overrun issued");

	property p_dir_word_ok;
		@(posedge clk_in) disable iff (!rst_n_in)
		dreq_in.valid && dreq_in.direct && (dreq_in.width == CADSC_W_WORD)
		&& (ea_sum <= DIR_LIM_WORD) |=> dvalid_q && !dir_err_q;
	endproperty
	a_dir_word_ok: assert property (p_dir_word_ok) else $error("direct word refused");

	// Target and decision are frozen at the branch, before the slot writes
	property p_ind_target;
		@(posedge clk_in) disable iff (!rst_n_in)
		s_dly_issue and (ret_in.br == CADSC_BR_IND)
		|=> tgt_q == ($past(ret_in.reg_val) & MASK_HALF);
	endproperty
	a_ind_target: assert property (p_ind_target) else $error("jump target moved");

	property p_flag_hold;
		@(posedge clk_in) disable iff (!rst_n_in)
		s_dly_issue and (ret_in.br == CADSC_BR_REL) |=> tgt_go_q == $past(ret_in.cond_ok);
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("branch decision moved");

	// The slot ends on the frozen target, with no extra bubble
	property p_redirect;
		@(posedge clk_in) disable iff (!rst_n_in)
		s_slot_done and tgt_go_q |=> pc_q == $past(tgt_q) && !in_slot_q;
	endproperty
	a_redirect: assert property (p_redirect) else $error("slot redirect wrong");

	property p_dly_cost;
		@(posedge clk_in) disable iff (!rst_n_in)
		s_dly_issue |=> !stall_q ##1 !stall_q;
	endproperty
	a_dly_cost: assert property (p_dly_cost) else $error("delayed branch stalled");

	property p_slot_nop;
		@(posedge clk_in) disable iff (!rst_n_in)
		s_slot_done and ret_in.undef |=> slot_nop_q;
	endproperty
	a_slot_nop: assert property (p_slot_nop) else $error("slot undefined not squashed");

	// Hazard: a stall here would drop the next sequential instruction
	property p_not_taken;
		@(posedge clk_in) disable iff (!rst_n_in)
		(st_q == CADSC_ST_RUN) && is_br && !ret_in.delayed && !br_taken |=> !stall_q;
	endproperty
	a_not_taken: assert property (p_not_taken) else $error("not taken stalled");

endmodule : cadsc_ctrl
`default_nettype wire

/* File: cadsc_pkg.sv */
// Package for the core alignment and delayed-branch control block
package cadsc_pkg;
	localparam int unsigned ADDR_W         = 32;            // Flat linear address width
	localparam logic [31:0] VEC_BASE_RST   = 32'h000FFC00;  // Vector table base after reset
	localparam logic [31:0] VEC_TOP_RST    = 32'h000FFFFF;  // Last byte of initial table
	localparam logic [31:0] DIR_LIM_BYTE   = 32'h000000FF;  // Direct window, byte
	localparam logic [31:0] DIR_LIM_HALF   = 32'h000001FF;  // Direct window, halfword
	localparam logic [31:0] DIR_LIM_WORD   = 32'h000003FF;  // Direct window, word
	localparam logic [31:0] MASK_HALF      = 32'hFFFFFFFE;  // Clears bit 0
	localparam logic [31:0] MASK_WORD      = 32'hFFFFFFFC;  // Clears bits 1..0
	localparam logic [31:0] PC_STEP16      = 32'h00000002;  // Halfword step
	localparam logic [31:0] PC_STEP32      = 32'h00000004;  // Two-halfword step
	localparam logic [31:0] PC_STEP48      = 32'h00000006;  // Three-halfword step
	localparam logic [31:0] MASK_NONE      = 32'hFFFFFFFF;  // Byte access, address kept
	localparam logic [1:0]  TAKEN_CYCLES   = 2'h2;          // Non-delayed taken branch cost
	localparam logic [1:0]  ONE_CYCLE      = 2'h1;          // Single-cycle cost

	typedef enum logic [1:0] {
		CADSC_W_BYTE = 2'b00,
		CADSC_W_HALF = 2'b01,
		CADSC_W_WORD = 2'b10
	} cadsc_width_t;

	typedef enum logic [1:0] {
		CADSC_ILEN_16 = 2'b00,
		CADSC_ILEN_32 = 2'b01,
		CADSC_ILEN_48 = 2'b10
	} cadsc_ilen_t;

	typedef enum logic [2:0] {
		CADSC_BR_NONE = 3'b000,  // Not a branch
		CADSC_BR_REL  = 3'b001,  // Relative or conditional branch
		CADSC_BR_IND  = 3'b010,  // Register-indirect jump
		CADSC_BR_CALL = 3'b011,  // Call (relative or indirect)
		CADSC_BR_RET  = 3'b100   // Return via return pointer
	} cadsc_br_t;

	typedef enum logic [1:0] {
		CADSC_ST_RUN  = 2'b00,   // Normal issue
		CADSC_ST_SLOT = 2'b01,   // Next retire is the delay slot
		CADSC_ST_BUB  = 2'b10    // Extra cycle of a taken plain branch
	} cadsc_state_t;

	// One retiring instruction, as reported by decode/execute
	typedef struct packed {
		logic          valid;     // Instruction retires this cycle
		cadsc_ilen_t   ilen;      // Encoded length
		cadsc_br_t     br;        // Branch kind
		logic          delayed;   // Has a delay slot
		logic          cond_ok;   // Condition true on current flags
		logic          undef;     // Undefined opcode
		logic [31:0]   rel_tgt;   // Relative target
		logic [31:0]   reg_val;   // Indirect register value now
	} cadsc_retire_t;

	// One data access request
	typedef struct packed {
		logic          valid;     // Access wanted
		cadsc_width_t  width;     // Byte, halfword or word
		logic          direct;    // Direct-addressing form
		logic [31:0]   base;      // Base register value
		logic [31:0]   index;     // Index or displacement
	} cadsc_dreq_t;
endpackage : cadsc_pkg

/* File: cadsc_mem_model.sv */
// Data memory partner that logs accesses issued by the core
`timescale 1ns/1ps
`default_nettype none
module cadsc_mem_model
	import cadsc_pkg::*;
(
	input  wire logic         clk_in,    // Core clock
	input  wire logic         rst_n_in,  // Async reset, active low
	input  wire logic         valid_in,  // Access issued
	input  wire logic [31:0]  addr_in,   // Aligned address
	input  wire cadsc_width_t width_in,  // Access width
	output var  int           n_acc_out, // Accesses seen
	output var  int           n_mis_out  // Misaligned accesses seen
);
	// No ready line on this bus, so every access is taken at once
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			n_acc_out <= 0;
			n_mis_out <= 0;
		end else if (valid_in) begin
			n_acc_out <= n_acc_out + 1;
			if ((width_in == CADSC_W_WORD && addr_in[1:0] != 2'h0) ||
			    (width_in == CADSC_W_HALF && addr_in[0])) begin
				n_mis_out <= n_mis_out + 1;
			end
		end
	end
endmodule : cadsc_mem_model
`default_nettype wire

/* File: tb_cadsc.sv */
// Self-checking bench for the alignment and delayed-branch control
`timescale 1ns/1ps
`default_nettype none
module tb;
	import cadsc_pkg::*;
	logic          clk_in = 1'b0;
	logic          rst_n_in = 1'b0;
	cadsc_retire_t ret_in = '0;
	cadsc_dreq_t   dreq_in = '0;
	logic          irq_req_in = 1'b0, nmi_req_in = 1'b0, trace_en_in = 1'b0;
	logic          tbp_we_in = 1'b0, rp_we_in = 1'b0;
	logic [31:0]   tbp_wdata_in = '0, rp_wdata_in = '0;
	logic [31:0]   pc_out, daddr_out, rp_out, tbp_out;
	cadsc_width_t  dwidth_out;
	logic          dvalid_out, dir_err_out, in_slot_out, slot_nop_out;
	logic          irq_ack_out, nmi_ack_out, trace_trap_out, stall_out;
	logic          slot_prev = 1'b0;
	logic [33:0]   q[$];
	int            failures = 0, n_checks = 0, cyc = 0, n_pushed = 0;
	int            n_err = 0, n_stall = 0, n_nop = 0, n_leak = 0, n_acc, n_mis;
	logic [31:0]   pc, b, x;

	cadsc_ctrl cadsc_ctrl_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .ret_in(ret_in),
		.dreq_in(dreq_in), .irq_req_in(irq_req_in), .nmi_req_in(nmi_req_in),
		.trace_en_in(trace_en_in), .tbp_we_in(tbp_we_in), .tbp_wdata_in(tbp_wdata_in),
		.rp_wdata_in(rp_wdata_in), .rp_we_in(rp_we_in), .pc_out(pc_out),
		.daddr_out(daddr_out), .dwidth_out(dwidth_out), .dvalid_out(dvalid_out),
		.dir_err_out(dir_err_out), .rp_out(rp_out), .tbp_out(tbp_out),
		.in_slot_out(in_slot_out), .slot_nop_out(slot_nop_out),
		.irq_ack_out(irq_ack_out), .nmi_ack_out(nmi_ack_out),
		.trace_trap_out(trace_trap_out), .stall_out(stall_out));
	cadsc_mem_model cadsc_mem_model_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.valid_in(dvalid_out), .addr_in(daddr_out), .width_in(dwidth_out),
		.n_acc_out(n_acc), .n_mis_out(n_mis));

	always #5 clk_in = ~clk_in;

	task automatic chk(string nm, logic [33:0] seen, logic [33:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic summarize;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize

	// Hang guard; the whole sequence needs well under a thousand cycles
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			summarize();
		end
	end

	// Output watcher: data results against notes, event pulses counted
	always @(posedge clk_in) begin
		if (rst_n_in) begin
			if (dvalid_out && q.size() == 0) chk("extra", 34'h1, 34'h0);
			else if (dvalid_out) chk("dacc", {dwidth_out, daddr_out}, q.pop_front());
			if (slot_prev && (irq_ack_out || nmi_ack_out || trace_trap_out)) n_leak++;
			n_err += dir_err_out;
			n_stall += stall_out;
			n_nop += slot_nop_out;
		end
		slot_prev = in_slot_out | (ret_in.valid & ret_in.delayed);
	end

	// Masks and window limits follow the width of the access
	function automatic logic [31:0] msk(cadsc_width_t w);
		return (w == CADSC_W_WORD) ? MASK_WORD : (w == CADSC_W_HALF) ? MASK_HALF : 32'hFFFFFFFF;
	endfunction : msk
	function automatic logic [31:0] lim(cadsc_width_t w);
		return (w == CADSC_W_WORD) ? DIR_LIM_WORD : (w == CADSC_W_HALF) ? DIR_LIM_HALF : DIR_LIM_BYTE;
	endfunction : lim

	// Caller lowers valid after a burst, so requests run back to back
	task automatic dacc(cadsc_width_t w, logic d, logic [31:0] bb, logic [31:0] xx);
		logic [31:0] s;
		s = bb + xx;
		@(negedge clk_in);
		dreq_in = '{1'b1, w, d, bb, xx};
		if (!d || s <= lim(w)) begin
			q.push_back({w, s & msk(w)});
			n_pushed++;
		end
	endtask : dacc

	task automatic rt(cadsc_br_t br, logic dl, logic c, logic u, logic [31:0] t, cadsc_ilen_t l);
		@(negedge clk_in);
		ret_in = '{1'b1, l, br, dl, c, u, t, t};
	endtask : rt

	task automatic idle(int n);
		@(negedge clk_in);
		ret_in.valid = 1'b0;
		rp_we_in = 1'b0;
		repeat (n) @(negedge clk_in);
	endtask : idle

	initial begin
		void'($urandom(32'h5a07781c));
		repeat (5) @(negedge clk_in);
		rst_n_in = 1'b1;
		chk("tbp", tbp_out, VEC_BASE_RST);
		chk("pc0", pc_out, 34'h0);
		pc = 32'h0;
		for (int i = 0; i < 3; i++) begin
			rt(CADSC_BR_NONE, 1'b0, 1'b0, 1'b0, 32'h0, cadsc_ilen_t'(i));
			pc = pc + 2 * (i + 1);
			@(posedge clk_in) #1 chk("pcseq", pc_out, pc);
		end
		// Plain branches: odd target taken, then one not taken
		rt(CADSC_BR_REL, 1'b0, 1'b1, 1'b0, 32'h00001235, CADSC_ILEN_16);
		idle(2);
		chk("pcodd", pc_out, 34'h1234);
		rt(CADSC_BR_REL, 1'b0, 1'b0, 1'b0, 32'h00003001, CADSC_ILEN_16);
		idle(2);
		chk("pcnt", pc_out, 34'h1236);
		chk("stall", n_stall, 34'h1);
		// Delayed jump with events pending; undefined op and reg write in slot
		irq_req_in = 1'b1;
		nmi_req_in = 1'b1;
		trace_en_in = 1'b1;
		rt(CADSC_BR_IND, 1'b1, 1'b1, 1'b0, 32'h00002000, CADSC_ILEN_16);
		@(posedge clk_in) #1 chk("slot", in_slot_out, 34'h1);
		chk("pcslot", pc_out, 34'h1238);
		rt(CADSC_BR_NONE, 1'b0, 1'b1, 1'b1, 32'h00000077, CADSC_ILEN_16);
		rp_we_in = 1'b1;
		rp_wdata_in = 32'h00000ABC;
		@(posedge clk_in) #1 chk("pcind", pc_out, 34'h2000);
		chk("rpw", rp_out, 34'hABC);
		idle(2);
		irq_req_in = 1'b0;
		nmi_req_in = 1'b0;
		trace_en_in = 1'b0;
		chk("leak", n_leak, 34'h0);
		chk("nop", n_nop, 34'h1);
		// Delayed branch decided on flags before the slot
		rt(CADSC_BR_REL, 1'b1, 1'b0, 1'b0, 32'h00004000, CADSC_ILEN_16);
		rt(CADSC_BR_NONE, 1'b0, 1'b1, 1'b0, 32'h0, CADSC_ILEN_16);
		idle(1);
		chk("pccond", pc_out, 34'h2004);
		// Delayed call then delayed return whose slot rewrites the pointer
		rt(CADSC_BR_CALL, 1'b1, 1'b1, 1'b0, 32'h00005000, CADSC_ILEN_16);
		@(posedge clk_in) #1 chk("rpcall", rp_out, 34'h2008);
		rt(CADSC_BR_NONE, 1'b0, 1'b0, 1'b0, 32'h0, CADSC_ILEN_16);
		rt(CADSC_BR_RET, 1'b1, 1'b1, 1'b0, 32'h0, CADSC_ILEN_16);
		rt(CADSC_BR_NONE, 1'b0, 1'b0, 1'b0, 32'h0, CADSC_ILEN_16);
		rp_we_in = 1'b1;
		rp_wdata_in = 32'h00006000;
		idle(1);
		chk("pcret", pc_out, 34'h2008);
		// Events outside a slot are taken one cycle on; NMI beats the interrupt
		irq_req_in = 1'b1;
		trace_en_in = 1'b1;
		rt(CADSC_BR_NONE, 1'b0, 1'b0, 1'b0, 32'h0, CADSC_ILEN_16);
		@(posedge clk_in) #1 chk("evt", {irq_ack_out, nmi_ack_out, trace_trap_out}, 34'h5);
		@(negedge clk_in) nmi_req_in = 1'b1;
		@(posedge clk_in) #1 chk("nmi", {irq_ack_out, nmi_ack_out}, 34'h1);
		idle(1);
		irq_req_in = 1'b0;
		nmi_req_in = 1'b0;
		trace_en_in = 1'b0;
		tbp_wdata_in = 32'h00020000;
		@(negedge clk_in) tbp_we_in = 1'b1;
		@(negedge clk_in) tbp_we_in = 1'b0;
		chk("tbpw", tbp_out, 34'h20000);
		// Random odd bases over all widths, then window edges
		for (int k = 0; k < 12; k++) begin
			b = $urandom() | 32'h1;
			x = $urandom();
			dacc(cadsc_width_t'(k % 3), 1'b0, b, x);
		end
		for (int w = 0; w < 3; w++) begin
			dacc(cadsc_width_t'(w), 1'b1, 32'h0, lim(cadsc_width_t'(w)));
			dacc(cadsc_width_t'(w), 1'b1, 32'h1, lim(cadsc_width_t'(w)));
		end
		@(negedge clk_in) dreq_in.valid = 1'b0;
		repeat (3) @(negedge clk_in);
		chk("direrr", n_err, 34'h3);
		chk("left", q.size(), 34'h0);
		chk("nacc", n_acc, n_pushed);
		chk("nmis", n_mis, 34'h0);
		summarize();
	end
endmodule : tb
`default_nettype wire
